// File: bench/wdh_core_model.sv
`timescale 1ns/1ps
// Stand-in for the processor core: it only issues one-cycle instruction strobes
module wdh_core_model (
  input wire logic ref_clk_in,
  output wdh_pkg::wdh_cmd_s cmd_out
);
  import wdh_pkg::*;
  initial cmd_out = '0;
  // Strobe is raised after one edge and dropped after the next, so it is taken once
  task automatic issue(input logic [3:0] c);
    @(posedge ref_clk_in);
    cmd_out <= c;
    @(posedge ref_clk_in);
    cmd_out <= '0;
  endtask
  // In dual mode software owes both halves, otherwise a time-out follows
  task automatic clear_pair();
    issue(4'h2);
    issue(4'h1);
  endtask
endmodule

// File: bench/wdh_watchdog_halt_tb.sv
`timescale 1ns/1ps
module wdh_watchdog_halt_tb;
  import wdh_pkg::*;
  logic clk, rst_b, wr, rd, emi, sfull, xrst_n, wosc, rd_q;
  logic osc_run, osc_pin, chip_rst, warm, halted, res_nx, int_ent, to_f, pd_f;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdat, rdat, pa;
  logic [2:0] iflg, ien;
  wdh_cmd_s cmd;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int tests_run = 0;
  int warm_cnt = 0;
  int n, b;

  wdh_core_model i_wdh_core_model (.ref_clk_in(clk), .cmd_out(cmd));
  wdh_watchdog_halt i_wdh_watchdog_halt (
    .ref_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdat), .cmd_in(cmd),
    .int_flags_in(iflg), .int_enable_in(ien), .emi_in(emi), .stack_full_in(sfull),
    .port_a_in(pa), .ext_reset_n_pin_in(xrst_n), .wdt_osc_in(wosc),
    .osc_run_out(osc_run), .osc_out_pin_out(osc_pin), .chip_reset_out(chip_rst),
    .warm_reset_out(warm), .halted_out(halted), .resume_next_out(res_nx),
    .int_entry_out(int_ent), .timeout_flag_out(to_f), .powerdown_flag_out(pd_f));

  // System clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog oscillator runs free at four system clocks, phase unrelated
  initial begin
    wosc = 1'b0;
    #37;
    forever #200 wosc = ~wosc;
  end

  // Warm reset pulses are counted so a silent halt can be proven silent
  always @(posedge clk) begin
    rd_q <= rd;
    if (warm === 1'b1) begin
      warm_cnt <= warm_cnt + 1;
    end
  end
  // Read data stands only in the cycle after the strobe; compare mid-cycle
  always @(negedge clk) begin
    if (rd_q === 1'b1) begin
      chk(16'(rdat), 16'(exp_q.pop_front()));
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Expected value is noted before the strobe goes out
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Sample just after the edge so that edge's updates have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: sig = (chip_rst === 1'b0);
      1: sig = (chip_rst === 1'b1);
      2: sig = (res_nx === 1'b1);
      3: sig = (int_ent === 1'b1);
      4: sig = (warm === 1'b1);
      default: sig = (halted === 1'b0);
    endcase
  endfunction

  // Bounded wait; n holds the cycles it took, a run-out counts as a mismatch
  task automatic wait_on(input int w, input int lim);
    n = 0;
    while (!sig(w)) begin
      cyc(1);
      n++;
      if (n > lim) begin
        chk(16'h0, 16'h1);
        stop_test();
      end
    end
  endtask

  initial begin
    void'($urandom(32'h54D92D59));
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdat = 8'h00;
    emi = 1'b1;
    sfull = 1'b0;
    xrst_n = 1'b1;
    pa = 8'hFF;
    iflg = 3'h0;
    ien = 3'h7;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wait_on(0, 1100);
    // Power-up contents, read-only status and an unmapped place
    wr_reg(ADDR_STATUS, 8'hFF);
    rd_reg(ADDR_STATUS, 8'h00);
    rd_reg(ADDR_OPTION, OPTION_RST);
    rd_reg(ADDR_WAKEMASK, WAKEMASK_RST);
    rd_reg(10'h3FC, 8'h00);
    // Oscillator pin: pulled high with a crystal, sysclk/4 in RC mode
    cyc(8);
    chk(16'(osc_pin), 16'h1);
    wr_reg(ADDR_OPTION, 8'h09);
    cyc(2);
    b = 0;
    for (int i = 0; i < 8; i++) begin
      n = int'(osc_pin);
      cyc(1);
      b += int'(osc_pin !== n[0]);
    end
    chk(16'(b), 16'h4);
    // Clears spaced so that ignored clears would let the dog bite
    wr_reg(ADDR_OPTION, 8'h01);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        wr_reg(ADDR_OPTION, 8'h05);
      end
      cyc(4000 + $urandom_range(999));
      chk(16'(chip_rst), 16'h0);
      if (i < 2) begin
        i_wdh_core_model.issue(4'h4);
      end else begin
        i_wdh_core_model.clear_pair();
      end
    end
    // A lone first half must not restart the 2^12 count
    cyc(8000);
    i_wdh_core_model.issue(4'h2);
    wait_on(1, 9000);
    chk(16'(n >= 8360 && n <= 8410), 16'h1);
    wait_on(0, 1100);
    rd_reg(ADDR_STATUS, 8'h20);
    // Instruction-clocked dog sleeps in halt; only an enabled port bit wakes
    b = $urandom_range(7);
    wr_reg(ADDR_OPTION, 8'h03);
    wr_reg(ADDR_WAKEMASK, 8'h01 << b);
    i_wdh_core_model.issue(4'h8);
    #1;
    chk(16'({osc_run, halted, to_f, pd_f}), 16'h5);
    n = warm_cnt;
    cyc(17000);
    chk(16'(warm_cnt - n), 16'h0);
    chk(16'(halted), 16'h1);
    @(posedge clk);
    pa <= ~(8'h01 << ((b + 1) % 8));
    cyc(40);
    chk(16'(halted), 16'h1);
    @(posedge clk);
    pa <= ~((8'h01 << ((b + 1) % 8)) | (8'h01 << b));
    wait_on(2, 1100);
    chk(16'(n >= 1024 && n <= 1040), 16'h1);
    @(posedge clk);
    pa <= 8'hFF;
    // Clear is void while disabled, effective clear drops the power-down flag
    wr_reg(ADDR_OPTION, 8'h00);
    i_wdh_core_model.issue(4'h4);
    #1;
    chk(16'(pd_f), 16'h1);
    wr_reg(ADDR_OPTION, 8'h01);
    i_wdh_core_model.issue(4'h4);
    #1;
    chk(16'(pd_f), 16'h0);
    // Own-oscillator dog keeps counting in halt from zero, then warm reset
    i_wdh_core_model.issue(4'h8);
    wait_on(4, 17000);
    chk(16'(n >= 16370 && n <= 16400), 16'h1);
    cyc(2);
    chk(16'({chip_rst, to_f, pd_f}), 16'h3);
    rd_reg(ADDR_STATUS, 8'h30);
    wait_on(5, 1100);
    // Interrupt wake with the dog off; a flag already pending cannot wake
    wr_reg(ADDR_OPTION, 8'h00);
    b = $urandom_range(2);
    @(posedge clk);
    iflg <= 3'(1 << b);
    ien <= 3'($urandom_range(7)) | 3'(1 << ((b + 1) % 3));
    i_wdh_core_model.issue(4'h8);
    cyc(50);
    chk(16'(halted), 16'h1);
    @(posedge clk);
    iflg <= 3'(1 << b) | 3'(1 << ((b + 1) % 3));
    wait_on(3, 1100);
    chk(16'(n >= 1024 && n <= 1040), 16'h1);
    // Full stack turns an interrupt wake into a plain continuation
    @(posedge clk);
    iflg <= 3'h0;
    sfull <= 1'b1;
    emi <= 1'($urandom_range(1));
    i_wdh_core_model.issue(4'h8);
    @(posedge clk);
    iflg <= 3'(1 << b);
    wait_on(2, 1100);
    chk(16'(int_ent), 16'h0);
    // Reset pin wakes a halted part through a full chip reset
    @(posedge clk);
    iflg <= 3'h0;
    i_wdh_core_model.issue(4'h8);
    @(posedge clk);
    xrst_n <= 1'b0;
    wait_on(1, 20);
    @(posedge clk);
    xrst_n <= 1'b1;
    wait_on(0, 1100);
    rd_reg(ADDR_STATUS, 8'h10);
    cyc(2);
    stop_test();
  end
endmodule

// File: rtl/wdh_pkg.sv
package wdh_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h0A;
  localparam logic [7:0] IDX_OPTION = 8'h20;
  localparam logic [7:0] IDX_WAKEMASK = 8'h21;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OPTION = {IDX_OPTION, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WAKEMASK = {IDX_WAKEMASK, 2'b00};

  // Status field positions
  localparam int STAT_TO_BIT = 5;
  localparam int STAT_PDF_BIT = 4;

  // Option register reset: enabled, own oscillator, single clear, crystal, 2^16
  localparam logic [7:0] OPTION_RST = 8'h41;
  localparam logic [7:0] WAKEMASK_RST = 8'h00;

  // Watchdog chain
  localparam int DOG_W = 16;
  localparam logic [DOG_W-1:0] DOG_ONES = 16'hFFFF;
  localparam logic [DOG_W-1:0] DOG_ONE = 16'h0001;
  localparam logic [2:0] DIV_SEL_MAX = 3'h4;

  // Start-up wait after wake or reset, in system clock periods
  localparam int SST_CYCLES = 1024;
  localparam int SST_W = $clog2(SST_CYCLES);
  localparam logic [SST_W-1:0] SST_LAST = SST_W'(SST_CYCLES - 1);

  // Synchroniser layout: port A bits, then reset pin, then watchdog oscillator
  localparam int SYNC_W = 10;
  localparam int SYNC_RST_BIT = 8;
  localparam int SYNC_WOSC_BIT = 9;
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h3FF;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_WAKE = 2'b10,
    ST_RESET = 2'b11
  } wdh_state_e;

  // Option register layout, bit 0 first from the right
  typedef struct packed {
    logic spare;
    logic [2:0] div_sel;
    logic rc;
    logic dual;
    logic src;
    logic en;
  } wdh_opt_s;

  // Instruction strobes from the core, one cycle each
  typedef struct packed {
    logic halt;
    logic clr_single;
    logic clr_first;
    logic clr_second;
  } wdh_cmd_s;

endpackage

// File: rtl/wdh_watchdog_halt.sv
`timescale 1ns/1ps
module wdh_watchdog_halt (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [wdh_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire wdh_pkg::wdh_cmd_s cmd_in,
  input wire logic [2:0] int_flags_in,
  input wire logic [2:0] int_enable_in,
  input wire logic emi_in,
  input wire logic stack_full_in,
  input wire logic [7:0] port_a_in,
  input wire logic ext_reset_n_pin_in,
  input wire logic wdt_osc_in,
  output logic osc_run_out,
  output logic osc_out_pin_out,
  output logic chip_reset_out,
  output logic warm_reset_out,
  output logic halted_out,
  output logic resume_next_out,
  output logic int_entry_out,
  output logic timeout_flag_out,
  output logic powerdown_flag_out
);
  import wdh_pkg::*;

  function automatic logic [DOG_W-1:0] dog_last(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > DIV_SEL_MAX) ? DIV_SEL_MAX : sel;
    return DOG_ONES >> (DIV_SEL_MAX - s);
  endfunction

  wdh_state_e st_q;
  wdh_opt_s opt_q;
  logic [7:0] wake_mask_q;
  logic [SYNC_W-1:0] sync_s1_q, sync_s2_q, sync_s3_q, stab_q, stab_d;
  logic [DOG_W-1:0] dog_cnt_q;
  logic [SST_W-1:0] sst_q;
  logic [1:0] sys_div_q;
  logic [2:0] int_snap_q, wake_flags_q;
  logic first_seen_q, second_seen_q;
  logic to_q, pdf_q;
  logic osc_run_q, osc_out_q, chip_reset_q, warm_q, halted_q;
  logic resume_q, int_entry_q, wake_int_q, wake_warm_q;
  logic [7:0] rd_data_q;
  logic ext_low, wosc_rise, instr_tick, dog_tick, dog_clr, ovf, halt_go;
  logic [7:0] port_fall;
  logic [2:0] new_int;
  logic wake_port, wake_int_ev, serviceable;

  // Three-stage synchroniser for pins; third stage feeds only the agreement logic
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_s1_q <= SYNC_RST;
      sync_s2_q <= SYNC_RST;
      sync_s3_q <= SYNC_RST;
      stab_q <= SYNC_RST;
    end else begin
      sync_s1_q <= {wdt_osc_in, ext_reset_n_pin_in, port_a_in};
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
      stab_q <= stab_d;
    end
  end

  // A change counts only once stages two and three agree
  assign stab_d = (sync_s2_q & ~(sync_s2_q ^ sync_s3_q)) | (stab_q & (sync_s2_q ^ sync_s3_q));
  assign ext_low = ~stab_q[SYNC_RST_BIT];
  assign wosc_rise = stab_d[SYNC_WOSC_BIT] & ~stab_q[SYNC_WOSC_BIT];
  assign port_fall = stab_q[7:0] & ~stab_d[7:0];

  // Instruction clock divider; frozen in halt since the system clock is off
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sys_div_q <= 2'h0;
    end else if (st_q != ST_HALT) begin
      sys_div_q <= sys_div_q + 2'h1;
    end
  end

  assign instr_tick = (st_q != ST_HALT) && (sys_div_q == 2'h3);

  // Pull-high level unless RC mode exports the quarter-rate clock
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_out_q <= 1'b1;
    end else begin
      osc_out_q <= (opt_q.rc && st_q != ST_HALT) ? sys_div_q[1] : 1'b1;
    end
  end

  // Source select: own oscillator keeps running through halt
  assign dog_tick = opt_q.src ? instr_tick : wosc_rise;
  assign halt_go = (st_q == ST_RUN) && cmd_in.halt && !ovf && !ext_low;

  // Clear instructions act only while the core executes and the dog is enabled
  assign dog_clr = opt_q.en && (st_q == ST_RUN) &&
                   (opt_q.dual ? ((cmd_in.clr_first | first_seen_q) &
                                  (cmd_in.clr_second | second_seen_q))
                               : cmd_in.clr_single);

  assign ovf = opt_q.en && dog_tick && !ext_low && (st_q != ST_RESET) &&
               (dog_cnt_q == dog_last(opt_q.div_sel));

  // Dual-clear bookkeeping; either order of the pair is accepted
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_seen_q <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (dog_clr || !opt_q.dual || !opt_q.en || ext_low || st_q == ST_RESET) begin
      first_seen_q <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (st_q == ST_RUN) begin
      first_seen_q <= first_seen_q | cmd_in.clr_first;
      second_seen_q <= second_seen_q | cmd_in.clr_second;
    end
  end

  // Single counter holds prescaler and divider, so a clear restarts the full period
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dog_cnt_q <= '0;
    end else if (!opt_q.en || st_q == ST_RESET || ext_low || dog_clr || halt_go || ovf) begin
      dog_cnt_q <= '0;
    end else if (dog_tick) begin
      dog_cnt_q <= dog_cnt_q + DOG_ONE;
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      to_q <= 1'b0;
      pdf_q <= 1'b0;
    end else begin
      if (ovf) begin
        to_q <= 1'b1;
      end else if (dog_clr || halt_go) begin
        to_q <= 1'b0;
      end
      if (halt_go) begin
        pdf_q <= 1'b1;
      end else if (dog_clr) begin
        pdf_q <= 1'b0;
      end
    end
  end

  // Interrupt flags already pending at halt entry are masked out of wake
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_snap_q <= 3'h0;
    end else if (halt_go) begin
      int_snap_q <= int_flags_in;
    end
  end

  assign new_int = int_flags_in & ~int_snap_q;
  assign wake_int_ev = |new_int;
  assign wake_port = |(port_fall & wake_mask_q);
  // Sampled at end of the wait, so software state at that moment decides
  assign serviceable = emi_in && !stack_full_in && |(wake_flags_q & int_enable_in);

  // Halt, wake and start-up sequencing
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= ST_RESET;
      sst_q <= '0;
      chip_reset_q <= 1'b1;
      warm_q <= 1'b0;
      resume_q <= 1'b0;
      int_entry_q <= 1'b0;
      osc_run_q <= 1'b1;
      halted_q <= 1'b0;
      wake_int_q <= 1'b0;
      wake_warm_q <= 1'b0;
      wake_flags_q <= 3'h0;
    end else begin
      warm_q <= 1'b0;
      resume_q <= 1'b0;
      int_entry_q <= 1'b0;
      if (ext_low) begin
        // Pin low restarts the start-up wait each cycle, in any state
        st_q <= ST_RESET;
        sst_q <= '0;
        chip_reset_q <= 1'b1;
        osc_run_q <= 1'b1;
        halted_q <= 1'b0;
      end else begin
        case (st_q)
          ST_RUN: begin
            if (ovf) begin
              st_q <= ST_RESET;
              sst_q <= '0;
              chip_reset_q <= 1'b1;
            end else if (halt_go) begin
              st_q <= ST_HALT;
              osc_run_q <= 1'b0;
              halted_q <= 1'b1;
            end
          end
          ST_HALT: begin
            if (ovf || wake_port || wake_int_ev) begin
              st_q <= ST_WAKE;
              sst_q <= '0;
              osc_run_q <= 1'b1;
              warm_q <= ovf;
              wake_warm_q <= ovf;
              wake_int_q <= !ovf && !wake_port && wake_int_ev;
              wake_flags_q <= new_int;
            end
          end
          ST_WAKE: begin
            if (ovf) begin
              st_q <= ST_RESET;
              sst_q <= '0;
              chip_reset_q <= 1'b1;
              halted_q <= 1'b0;
            end else if (osc_run_q) begin
              if (sst_q == SST_LAST) begin
                st_q <= ST_RUN;
                halted_q <= 1'b0;
                if (!wake_warm_q) begin
                  int_entry_q <= wake_int_q && serviceable;
                  resume_q <= !(wake_int_q && serviceable);
                end
              end else begin
                sst_q <= sst_q + SST_W'(1);
              end
            end
          end
          ST_RESET: begin
            if (sst_q == SST_LAST) begin
              st_q <= ST_RUN;
              chip_reset_q <= 1'b0;
            end else begin
              sst_q <= sst_q + SST_W'(1);
            end
          end
          default: begin
            st_q <= ST_RESET;
            sst_q <= '0;
            chip_reset_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Option and wake-mask registers; writes take effect on the next edge
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opt_q <= OPTION_RST;
      wake_mask_q <= WAKEMASK_RST;
    end else if (wr_en_in) begin
      if (addr_in == ADDR_OPTION) begin
        opt_q <= wr_data_in;
      end
      if (addr_in == ADDR_WAKEMASK) begin
        wake_mask_q <= wr_data_in;
      end
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_q <= 8'h00;
    end else if (!rd_en_in) begin
      rd_data_q <= 8'h00;
    end else begin
      case (addr_in)
        ADDR_STATUS: begin
          rd_data_q <= 8'h00;
          rd_data_q[STAT_TO_BIT] <= to_q;
          rd_data_q[STAT_PDF_BIT] <= pdf_q;
        end
        ADDR_OPTION: rd_data_q <= opt_q;
        ADDR_WAKEMASK: rd_data_q <= wake_mask_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  assign rd_data_out = rd_data_q;
  assign osc_run_out = osc_run_q;
  assign osc_out_pin_out = osc_out_q;
  assign chip_reset_out = chip_reset_q;
  assign warm_reset_out = warm_q;
  assign halted_out = halted_q;
  assign resume_next_out = resume_q;
  assign int_entry_out = int_entry_q;
  assign timeout_flag_out = to_q;
  assign powerdown_flag_out = pdf_q;

  // The divider still moves on the halt edge itself, so stillness is checked one cycle on
  chk_halt_osc_off: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    halt_go |=> !osc_run_q && halted_q ##1 $stable(sys_div_q))
    else $error("oscillator not stopped on halt");

  chk_halt_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_q == ST_HALT) |-> halted_q && !osc_run_q)
    else $error("core not frozen while halted");

  chk_rc_clock_out: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (opt_q.rc && $past(opt_q.rc) && $past(st_q) != ST_HALT)
    |-> osc_out_q == $past(sys_div_q[1]))
    else $error("quarter clock not on oscillator output");

  // A reset pin edge may still raise chip reset while disabled, so it is left out
  chk_dog_disabled: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (!opt_q.en && !ext_low && st_q == ST_RUN) |=> dog_cnt_q == '0 && !$rose(to_q)
      && !$rose(chip_reset_q))
    else $error("disabled watchdog had an effect");

  chk_pin_clears_dog: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ext_low |=> dog_cnt_q == '0 && chip_reset_q && st_q == ST_RESET)
    else $error("reset pin did not clear the watchdog");

  chk_ovf_chip_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (ovf && st_q == ST_RUN) |=> chip_reset_q && to_q && st_q == ST_RESET)
    else $error("run overflow without chip reset");

  chk_ovf_warm_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (ovf && st_q == ST_HALT) |=> warm_q && to_q && !chip_reset_q ##1 !warm_q)
    else $error("halt overflow without warm reset");

  chk_warm_only_halt: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    warm_q |-> $past(st_q) == ST_HALT)
    else $error("warm reset outside halt");

  chk_single_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (opt_q.en && !opt_q.dual && st_q == ST_RUN && cmd_in.clr_single) |=> dog_cnt_q == '0)
    else $error("single clear missed");

  // A running count must survive a lone first half, whether or not a tick lands
  chk_dual_half_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (opt_q.en && opt_q.dual && !first_seen_q && !second_seen_q && cmd_in.clr_first
     && !cmd_in.clr_second && !halt_go && !ovf && !ext_low && dog_cnt_q != '0
     && st_q == ST_RUN)
    |=> dog_cnt_q != '0)
    else $error("dual mode cleared on one instruction");

  chk_halt_flags: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    halt_go |=> pdf_q && !to_q && dog_cnt_q == '0)
    else $error("halt entry flags wrong");

  chk_pdf_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (dog_clr && !halt_go) |=> !pdf_q)
    else $error("effective clear left the powerdown flag set");

  chk_instr_stop: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_q == ST_HALT && $past(st_q) == ST_HALT && opt_q.src) |-> $stable(dog_cnt_q))
    else $error("instruction clocked watchdog ran in halt");

  chk_stale_int: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_q == ST_HALT && !ext_low && !ovf && !wake_port && (int_flags_in & ~int_snap_q) == 3'h0)
    |=> st_q == ST_HALT)
    else $error("woken by a stale interrupt flag");

  chk_port_wake: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_q == ST_HALT && !ext_low && wake_port) |=> st_q == ST_WAKE && osc_run_q)
    else $error("enabled port edge did not wake");

  chk_int_wake: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_q == ST_HALT && !ext_low && !ovf && !wake_port && wake_int_ev)
    |=> st_q == ST_WAKE && wake_int_q)
    else $error("new interrupt flag did not wake");

  chk_wake_wait: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ($past(st_q) == ST_WAKE && st_q == ST_RUN) |-> $past(sst_q) == SST_LAST)
    else $error("wake wait length wrong");

  chk_wake_outcome: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ($past(st_q) == ST_WAKE && st_q == ST_RUN && !$past(wake_warm_q))
    |-> (resume_q ^ int_entry_q))
    else $error("wake end gave no single continuation");

  chk_status_bits: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (rd_en_in && addr_in == ADDR_STATUS)
    |=> rd_data_q[STAT_TO_BIT] == $past(to_q) && rd_data_q[STAT_PDF_BIT] == $past(pdf_q))
    else $error("status flags misplaced on read");

endmodule
